// file: hw/upsm_ev_if.sv
/*
 interface carrying the power-state manager's qualified events to the state core.
 assumes one clock domain; events are one-cycle pulses or levels as named.
*/
`timescale 1ns/10ps
interface upsm_ev_if;
   logic power_ok;
   logic sys_reset;
   logic cfg_done;
   logic decfg;
   logic suspend;
   logic wake;
   modport src  (output power_ok, sys_reset, cfg_done, decfg, suspend, wake);
   modport sink (input  power_ok, sys_reset, cfg_done, decfg, suspend, wake);
endinterface

// file: hw/upsm_event_qual.sv
/*
 event qualifier: turns the suspend, resume and wake levels into edge pulses for the state core; the two resets are ORed, other inputs pass through.
 assumes all inputs synchronous to i_clock.
*/
`timescale 1ns/10ps
module upsm_event_qual
   import upsm_pkg::*;
(
   // clock and reset
   input  wire logic i_clock,
   input  wire logic i_rstn,
   // raw inputs
   input  wire logic i_bus_power_sense,
   input  wire logic i_usb_bus_reset,
   input  wire logic i_pin_reset_n,
   input  wire logic i_cfg_done,
   input  wire logic i_decfg,
   input  wire logic i_suspend,
   input  wire logic i_resume,
   input  wire logic i_wake_event,
   // qualified events
   upsm_ev_if.src    ev
);
   logic suspend_r;
   logic resume_r;
   logic wake_r;

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         suspend_r <= 1'b0;
         resume_r  <= 1'b0;
         wake_r    <= 1'b0;
      end else begin
         suspend_r <= i_suspend;
         resume_r  <= i_resume;
         wake_r    <= i_wake_event;
      end
   end

   assign ev.power_ok  = i_bus_power_sense;
   assign ev.sys_reset = i_usb_bus_reset | ~i_pin_reset_n;
   assign ev.cfg_done  = i_cfg_done;
   assign ev.decfg     = i_decfg;
   // suspend is a level from the usb core; only its rise starts a suspend
   assign ev.suspend   = i_suspend & ~suspend_r;
   assign ev.wake      = (i_resume & ~resume_r) | (i_wake_event & ~wake_r);
endmodule

// file: hw/upsm_pkg.sv
/*
 the package of the usb power state manager: power states, suspend variant codes,
 module enable groups and timing constants.
 assumes nothing of its surroundings.
*/
package upsm_pkg;

   typedef enum logic [2:0] {
      UPSM_UNPOWERED,
      UPSM_NORMAL_UNCFG,
      UPSM_NORMAL_CFG,
      UPSM_SUSP_ZERO,
      UPSM_SUSP_ONE,
      UPSM_SUSP_DEEP,
      UPSM_SUSP_CLOCKED
   } upsm_state_e;

   // suspend-select field codes
   localparam logic [1:0] UPSM_SEL_ZERO    = 2'h0;
   localparam logic [1:0] UPSM_SEL_ONE     = 2'h1;
   localparam logic [1:0] UPSM_SEL_DEEP    = 2'h2;
   localparam logic [1:0] UPSM_SEL_CLOCKED = 2'h3;
   localparam logic [1:0] UPSM_SEL_RESET   = UPSM_SEL_DEEP;

   // module enable groups
   localparam int         UPSM_MOD_W       = 4;
   localparam logic [3:0] UPSM_MOD_ALL     = 4'hF;
   localparam logic [3:0] UPSM_MOD_UNCFG   = 4'h3;
   localparam logic [3:0] UPSM_MOD_NONE    = 4'h0;

   // reference clock and the short settle of the pll after wake
   localparam int         UPSM_CLK_MHZ     = 20;
   localparam int         UPSM_PLL_LOCK_NS = 200;
   localparam int         UPSM_PLL_LOCK_CYC = (UPSM_PLL_LOCK_NS * UPSM_CLK_MHZ + 999) / 1000;
   localparam int         UPSM_CNT_W       = 8;
   localparam logic [7:0] UPSM_CNT_ZERO    = 8'h00;

endpackage

// file: hw/upsm_power_manager.sv
/*
 power manager of a usb device: unpowered, normal unconfigured/configured and four
 suspend variants, module enables, pll gating, ready status and suspend-select field.
 assumes all inputs synchronous to the always-running reference clock; the usb core
 gives pulses for configuration and deconfiguration, levels for suspend and resume.
*/
//
// Behaviour
// [RQ1] unpowered, normal two sub-states, four suspends
// [RQ2] deep suspend from unconfigured never reaches configured
// [RQ3] bus powered sense tied high, unpowered unreachable
// [RQ4] no power at reset: stay unpowered
// [RQ5] power sense loss always goes unpowered
// [RQ6] four ways into normal state
// [RQ7] configured enables all modules, unconfigured subset
// [RQ8] normal entry unconfigured, configure moves configured
// [RQ9] deconfigure returns to unconfigured
// [RQ10] any system reset lands unconfigured
// [RQ11] ready set while in normal state
// [RQ12] resume keeps usb context then ready
// [RQ13] host reinitialises phy after deep suspend
// [RQ14] suspend only from normal, variant from select
// [RQ15] host writes select before suspend signaling
// [RQ16] resume or wake leaves any suspend
// [RQ17] unconfigured suspend uses deep, returns unconfigured
// [RQ18] deconfigure resets select to deep code
// [RQ19] pll gated in low power, reference runs
// [RQ20] select codes zero, one, deep, clocked
// [RQ21] usb or pin reset in suspend reinitialises
`timescale 1ns/10ps
module upsm_power_manager
   import upsm_pkg::*;
#(
   parameter int MOD_W = UPSM_MOD_W
) (
   // clock and reset
   input  wire logic             i_clock,
   input  wire logic             i_rstn,
   // power and reset sources
   input  wire logic             i_bus_power_sense,
   input  wire logic             i_usb_bus_reset,
   input  wire logic             i_pin_reset_n,
   // usb core events
   input  wire logic             i_cfg_done,
   input  wire logic             i_decfg,
   input  wire logic             i_suspend,
   input  wire logic             i_resume,
   input  wire logic             i_wake_event,
   // suspend-select field write
   input  wire logic             i_sel_we,
   input  wire logic [1:0]       i_sel_wdata,
   // status
   output logic [2:0]            o_state,
   output logic                  o_ready,
   output logic [1:0]            o_suspend_sel,
   output logic                  o_configured,
   output logic                  o_context_keep,
   // clock and module control
   output logic                  o_pll_en,
   output logic                  o_ref_clk_en,
   output logic [MOD_W-1:0]      o_mod_en
);

   upsm_ev_if ev();

   upsm_event_qual u_qual (
      .i_clock           (i_clock),
      .i_rstn            (i_rstn),
      .i_bus_power_sense (i_bus_power_sense),
      .i_usb_bus_reset   (i_usb_bus_reset),
      .i_pin_reset_n     (i_pin_reset_n),
      .i_cfg_done        (i_cfg_done),
      .i_decfg           (i_decfg),
      .i_suspend         (i_suspend),
      .i_resume          (i_resume),
      .i_wake_event      (i_wake_event),
      .ev                (ev)
   );

   upsm_state_e           state_r;
   upsm_state_e           state_nxt;
   logic [1:0]            sel_r;
   logic [1:0]            sel_nxt;
   logic                  ready_r;
   logic                  ctx_r;
   logic                  pll_r;
   logic                  refc_r;
   logic [MOD_W-1:0]      mod_r;
   logic [MOD_W-1:0]      mod_nxt;
   logic [UPSM_CNT_W-1:0] lock_r;
   logic                  in_normal;
   logic                  in_susp;
   logic                  pll_need;
   logic                  locked;
   upsm_state_e           susp_target;

   function automatic upsm_state_e sel_to_state(input logic [1:0] sel);
      unique case (sel)
         UPSM_SEL_ZERO:    sel_to_state = UPSM_SUSP_ZERO;
         UPSM_SEL_ONE:     sel_to_state = UPSM_SUSP_ONE;
         UPSM_SEL_DEEP:    sel_to_state = UPSM_SUSP_DEEP;
         UPSM_SEL_CLOCKED: sel_to_state = UPSM_SUSP_CLOCKED;
      endcase
   endfunction

   function automatic logic is_susp(input upsm_state_e s);
      is_susp = (s == UPSM_SUSP_ZERO) || (s == UPSM_SUSP_ONE) ||
                (s == UPSM_SUSP_DEEP) || (s == UPSM_SUSP_CLOCKED);
   endfunction

   assign in_normal = (state_r == UPSM_NORMAL_UNCFG) || (state_r == UPSM_NORMAL_CFG);
   assign in_susp   = is_susp(state_r);
   // unconfigured suspend is forced to the deep variant whatever the field says
   assign susp_target = (state_r == UPSM_NORMAL_UNCFG) ? UPSM_SUSP_DEEP : sel_to_state(sel_r); // RQ14 RQ17

   always_comb begin
      state_nxt = state_r;
      unique case (state_r) // RQ1
         UPSM_UNPOWERED: begin
            if (ev.power_ok)
               state_nxt = UPSM_NORMAL_UNCFG; // RQ6
         end
         UPSM_NORMAL_UNCFG: begin
            if (ev.suspend)
               state_nxt = susp_target; // RQ17
            else if (ev.cfg_done)
               state_nxt = UPSM_NORMAL_CFG; // RQ8
         end
         UPSM_NORMAL_CFG: begin
            if (ev.decfg)
               state_nxt = UPSM_NORMAL_UNCFG; // RQ9
            else if (ev.suspend)
               state_nxt = susp_target; // RQ14
         end
         default: begin
            // usb context is kept, so the sub-state left is the one resumed to;
            // deep suspend taken from unconfigured comes back unconfigured
            if (ev.wake)
               state_nxt = ctx_r ? UPSM_NORMAL_CFG : UPSM_NORMAL_UNCFG; // RQ16 RQ12 RQ2 RQ17
         end
      endcase
      if (ev.sys_reset && state_r != UPSM_UNPOWERED)
         state_nxt = UPSM_NORMAL_UNCFG; // RQ10 RQ21
      if (!ev.power_ok)
         state_nxt = UPSM_UNPOWERED; // RQ5 RQ3
   end

   always_comb begin
      sel_nxt = sel_r;
      if (i_sel_we)
         sel_nxt = i_sel_wdata; // RQ20
      if ((state_r == UPSM_NORMAL_CFG && ev.decfg) || ev.sys_reset)
         sel_nxt = UPSM_SEL_RESET; // RQ18
   end

   always_comb begin
      unique case (state_nxt)
         UPSM_NORMAL_CFG:   mod_nxt = MOD_W'(UPSM_MOD_ALL); // RQ7
         UPSM_NORMAL_UNCFG: mod_nxt = MOD_W'(UPSM_MOD_UNCFG); // RQ7
         UPSM_SUSP_CLOCKED: mod_nxt = MOD_W'(UPSM_MOD_ALL);
         default:           mod_nxt = MOD_W'(UPSM_MOD_NONE);
      endcase
   end

   // pll runs only where the modules are clocked; the clocked variant keeps it
   assign pll_need = (state_nxt == UPSM_NORMAL_UNCFG) || (state_nxt == UPSM_NORMAL_CFG) ||
                     (state_nxt == UPSM_SUSP_CLOCKED); // RQ19
   assign locked   = (lock_r == UPSM_CNT_W'(UPSM_PLL_LOCK_CYC));

   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         state_r <= UPSM_UNPOWERED; // RQ4
         sel_r   <= UPSM_SEL_RESET; // RQ20
         ctx_r   <= 1'b0;
         mod_r   <= MOD_W'(UPSM_MOD_NONE);
         pll_r   <= 1'b0;
         refc_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         sel_r   <= sel_nxt;
         mod_r   <= mod_nxt;
         pll_r   <= pll_need;
         refc_r  <= (state_nxt != UPSM_UNPOWERED) || ev.power_ok; // RQ19
         if (state_nxt == UPSM_NORMAL_UNCFG || state_nxt == UPSM_UNPOWERED)
            ctx_r <= 1'b0;
         else if (state_nxt == UPSM_NORMAL_CFG)
            ctx_r <= 1'b1; // RQ12
      end
   end

   // ready waits for the pll to settle so the host only sees it once clocks run
   always_ff @(posedge i_clock) begin
      if (!i_rstn) begin
         lock_r  <= UPSM_CNT_ZERO;
         ready_r <= 1'b0;
      end else begin
         if (!pll_need)
            lock_r <= UPSM_CNT_ZERO;
         else if (!locked)
            lock_r <= lock_r + UPSM_CNT_W'(1);
         ready_r <= (state_nxt == UPSM_NORMAL_UNCFG || state_nxt == UPSM_NORMAL_CFG) && locked; // RQ11 RQ12
      end
   end

   assign o_state        = state_r;
   assign o_ready        = ready_r;
   assign o_suspend_sel  = sel_r;
   assign o_configured   = ctx_r;
   assign o_context_keep = ctx_r;
   assign o_pll_en       = pll_r;
   assign o_ref_clk_en   = refc_r;
   assign o_mod_en       = mod_r;

   property p_unpowered_on_loss;
      @(posedge i_clock) disable iff (!i_rstn)
      !i_bus_power_sense |=> (state_r == UPSM_UNPOWERED);
   endproperty
   a_unpowered_on_loss: assert property (p_unpowered_on_loss) else $error("power loss did not unpower"); // RQ5

   property p_power_up;
      @(posedge i_clock) disable iff (!i_rstn)
      (state_r == UPSM_UNPOWERED) && i_bus_power_sense |=> (state_r == UPSM_NORMAL_UNCFG);
   endproperty
   a_power_up: assert property (p_power_up) else $error("power sense did not enter normal"); // RQ6

   property p_stay_unpowered;
      @(posedge i_clock) disable iff (!i_rstn)
      (state_r == UPSM_UNPOWERED) && !i_bus_power_sense |=> (state_r == UPSM_UNPOWERED);
   endproperty
   a_stay_unpowered: assert property (p_stay_unpowered) else $error("left unpowered without power"); // RQ4

   property p_deep_from_uncfg;
      @(posedge i_clock) disable iff (!i_rstn)
      (state_r == UPSM_NORMAL_UNCFG) && ev.suspend && ev.power_ok && !ev.sys_reset
      |=> (state_r == UPSM_SUSP_DEEP) && !o_configured;
   endproperty
   a_deep_from_uncfg: assert property (p_deep_from_uncfg) else $error("unconfigured suspend not deep"); // RQ17

   property p_no_deep_to_cfg;
      @(posedge i_clock) disable iff (!i_rstn)
      (state_r == UPSM_SUSP_DEEP) && !ctx_r |=> (state_r != UPSM_NORMAL_CFG);
   endproperty
   a_no_deep_to_cfg: assert property (p_no_deep_to_cfg) else $error("deep suspend went configured"); // RQ2

   property p_decfg_sel;
      @(posedge i_clock) disable iff (!i_rstn)
      (state_r == UPSM_NORMAL_CFG) && ev.decfg |=> (sel_r == UPSM_SEL_RESET);
   endproperty
   a_decfg_sel: assert property (p_decfg_sel) else $error("select not reset on deconfigure"); // RQ18

   property p_ready_normal;
      @(posedge i_clock) disable iff (!i_rstn)
      o_ready |-> (state_r == UPSM_NORMAL_UNCFG) || (state_r == UPSM_NORMAL_CFG);
   endproperty
   a_ready_normal: assert property (p_ready_normal) else $error("ready outside normal"); // RQ11

   property p_ready_rises;
      @(posedge i_clock) disable iff (!i_rstn)
      in_normal && i_bus_power_sense && !i_usb_bus_reset && i_pin_reset_n && !i_suspend && !$past(in_normal)
      ##1 (in_normal && i_bus_power_sense && !i_suspend)[*4] |-> ##[0:8] o_ready;
   endproperty
   a_ready_rises: assert property (p_ready_rises) else $error("ready not raised in normal"); // RQ12

   property p_mod_en;
      @(posedge i_clock) disable iff (!i_rstn)
      (state_r == UPSM_NORMAL_UNCFG) |-> (o_mod_en == MOD_W'(UPSM_MOD_UNCFG));
   endproperty
   a_mod_en: assert property (p_mod_en) else $error("unconfigured module enables wrong"); // RQ7

   property p_pll_gated;
      @(posedge i_clock) disable iff (!i_rstn)
      (state_r == UPSM_SUSP_DEEP) |-> !o_pll_en;
   endproperty
   a_pll_gated: assert property (p_pll_gated) else $error("pll running in deep suspend"); // RQ19

   property p_reset_in_susp;
      @(posedge i_clock) disable iff (!i_rstn)
      in_susp && i_bus_power_sense && !i_pin_reset_n |=> (state_r == UPSM_NORMAL_UNCFG);
   endproperty
   a_reset_in_susp: assert property (p_reset_in_susp) else $error("pin reset ignored in suspend"); // RQ21

   property p_susp_variant;
      @(posedge i_clock) disable iff (!i_rstn)
      (state_r == UPSM_NORMAL_CFG) && ev.suspend && !ev.decfg && !ev.sys_reset && ev.power_ok
      |=> (state_r == sel_to_state($past(sel_r)));
   endproperty
   a_susp_variant: assert property (p_susp_variant) else $error("wrong suspend variant"); // RQ14

   property p_cfg_done;
      @(posedge i_clock) disable iff (!i_rstn)
      (state_r == UPSM_NORMAL_UNCFG) && ev.cfg_done && !ev.suspend && !ev.sys_reset && ev.power_ok
      |=> (state_r == UPSM_NORMAL_CFG);
   endproperty
   a_cfg_done: assert property (p_cfg_done) else $error("configure did not reach configured"); // RQ8

   property p_decfg_state;
      @(posedge i_clock) disable iff (!i_rstn)
      (state_r == UPSM_NORMAL_CFG) && ev.decfg && ev.power_ok |=> (state_r == UPSM_NORMAL_UNCFG);
   endproperty
   a_decfg_state: assert property (p_decfg_state) else $error("deconfigure kept configured"); // RQ9

   property p_sys_reset;
      @(posedge i_clock) disable iff (!i_rstn)
      (state_r != UPSM_UNPOWERED) && ev.sys_reset && ev.power_ok
      |=> (state_r == UPSM_NORMAL_UNCFG) && (sel_r == UPSM_SEL_RESET);
   endproperty
   a_sys_reset: assert property (p_sys_reset) else $error("system reset not unconfigured"); // RQ10

   property p_wake_leaves;
      @(posedge i_clock) disable iff (!i_rstn)
      in_susp && ev.wake && ev.power_ok |=> in_normal;
   endproperty
   a_wake_leaves: assert property (p_wake_leaves) else $error("wake did not leave suspend"); // RQ16

   property p_wake_context;
      @(posedge i_clock) disable iff (!i_rstn)
      in_susp && ev.wake && ev.power_ok && !ev.sys_reset |=> (o_configured == $past(o_configured));
   endproperty
   a_wake_context: assert property (p_wake_context) else $error("usb context lost on resume"); // RQ12

   property p_susp_entry;
      @(posedge i_clock) disable iff (!i_rstn)
      in_susp && !$past(in_susp) |-> $past(in_normal);
   endproperty
   a_susp_entry: assert property (p_susp_entry) else $error("suspend entered from outside normal"); // RQ14

   property p_cfg_mod_en;
      @(posedge i_clock) disable iff (!i_rstn)
      (state_r == UPSM_NORMAL_CFG) |-> (o_mod_en == MOD_W'(UPSM_MOD_ALL));
   endproperty
   a_cfg_mod_en: assert property (p_cfg_mod_en) else $error("configured module enables wrong"); // RQ7

   property p_ref_runs;
      @(posedge i_clock) disable iff (!i_rstn)
      (state_r != UPSM_UNPOWERED) |-> o_ref_clk_en;
   endproperty
   a_ref_runs: assert property (p_ref_runs) else $error("reference clock off while powered"); // RQ19

   property p_unpowered_quiet;
      @(posedge i_clock) disable iff (!i_rstn)
      (state_r == UPSM_UNPOWERED) |-> !o_pll_en && !o_ready && (o_mod_en == MOD_W'(UPSM_MOD_NONE));
   endproperty
   a_unpowered_quiet: assert property (p_unpowered_quiet) else $error("activity while unpowered"); // RQ4

   property p_sel_write;
      @(posedge i_clock) disable iff (!i_rstn)
      i_sel_we && !ev.sys_reset && !((state_r == UPSM_NORMAL_CFG) && ev.decfg)
      |=> (o_suspend_sel == $past(i_sel_wdata));
   endproperty
   a_sel_write: assert property (p_sel_write) else $error("select write not taken"); // RQ20

endmodule

// file: tb/upsm_host_model.sv
/*
 behavioural usb host and wake source facing the power manager.
 assumes the bench calls its tasks from one process; outputs move only after rising edges.
*/
`timescale 1ns/10ps
module upsm_host_model (
   // clock
   input  wire logic       i_clock,
   // host requests
   output logic            o_cfg_done,
   output logic            o_decfg,
   output logic            o_sel_we,
   output logic [1:0]      o_sel_wdata,
   output logic            o_suspend,
   output logic            o_resume,
   output logic            o_wake_event
);
   logic [2:0] pulse_r;
   int         phy_inits;
   assign o_cfg_done = pulse_r[0];
   assign o_decfg    = pulse_r[1];
   assign o_sel_we   = pulse_r[2];
   initial begin
      pulse_r      = 3'h0;
      o_sel_wdata  = 2'h0;
      o_suspend    = 1'b0;
      o_resume     = 1'b0;
      o_wake_event = 1'b0;
      phy_inits    = 0;
   end
   // one-cycle pulse: 0 configure, 1 deconfigure, 2 select write
   task automatic pulse(input int kind, input logic [1:0] sel);
      @(posedge i_clock);
      pulse_r     <= 3'h1 << kind;
      o_sel_wdata <= sel;
      @(posedge i_clock);
      pulse_r     <= 3'h0;
      o_sel_wdata <= ~sel;
   endtask
   // select is written by the caller before this level rises in every suspend taken while powered
   task automatic suspend_bus();
      @(posedge i_clock);
      o_suspend <= 1'b1;
   endtask
   task automatic resume_bus(input logic use_wake);
      @(posedge i_clock);
      o_suspend <= 1'b0;
      if (use_wake) begin
         o_wake_event <= 1'b1;
      end else begin
         o_resume <= 1'b1;
      end
      repeat (2) @(posedge i_clock);
      o_wake_event <= 1'b0;
      o_resume     <= 1'b0;
   endtask
   // phy contents are gone after the deep variant, so the host rebuilds them
   task automatic phy_reinit();
      phy_inits++;
   endtask
endmodule

// file: tb/upsm_power_manager_tb.sv
/*
 self-checking bench of the power manager: drives power, resets and host traffic,
 notes each expected state and checks every state change from a monitor process.
 assumes the host model file and the design package are compiled first.
*/
`timescale 1ns/10ps
module upsm_power_manager_tb;
   import upsm_pkg::*;
   logic        i_clock;
   logic        i_rstn;
   logic        sense;
   logic        usb_rst;
   logic        pin_rstn;
   wire logic   cfg_done, decfg, sel_we, susp, resume, wake;
   wire logic [1:0] sel_wdata;
   logic [2:0]  o_state;
   logic        o_ready, o_configured, o_context_keep, o_pll_en, o_ref_clk_en;
   logic [1:0]  o_suspend_sel;
   logic [3:0]  o_mod_en;
   logic [2:0]  notes[$];
   logic [2:0]  prev;
   logic [2:0]  exp_st;
   int          error_cnt, checked, cycles;
   logic [1:0]  codes[4] = '{UPSM_SEL_ZERO, UPSM_SEL_ONE, UPSM_SEL_CLOCKED, UPSM_SEL_DEEP};
   logic [2:0]  sts[4]   = '{UPSM_SUSP_ZERO, UPSM_SUSP_ONE, UPSM_SUSP_CLOCKED, UPSM_SUSP_DEEP};

   upsm_host_model host (.i_clock(i_clock), .o_cfg_done(cfg_done), .o_decfg(decfg), .o_sel_we(sel_we),
      .o_sel_wdata(sel_wdata), .o_suspend(susp), .o_resume(resume), .o_wake_event(wake));
   upsm_power_manager dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_bus_power_sense(sense),
      .i_usb_bus_reset(usb_rst), .i_pin_reset_n(pin_rstn), .i_cfg_done(cfg_done), .i_decfg(decfg),
      .i_suspend(susp), .i_resume(resume), .i_wake_event(wake), .i_sel_we(sel_we),
      .i_sel_wdata(sel_wdata), .o_state(o_state), .o_ready(o_ready), .o_suspend_sel(o_suspend_sel),
      .o_configured(o_configured), .o_context_keep(o_context_keep), .o_pll_en(o_pll_en),
      .o_ref_clk_en(o_ref_clk_en), .o_mod_en(o_mod_en));

   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end

   task automatic final_report();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [3:0] e, input logic [3:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic step(input logic [2:0] s);
      notes.push_back(s);
   endtask

   // waits for the monitor to consume every note, bounded
   task automatic settle();
      int n;
      n = 0;
      while (notes.size() != 0 && n < 10) begin
         @(negedge i_clock);
         n++;
      end
      chk("pending notes", 4'h0, 4'(notes.size()));
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      while (o_ready !== 1'b1 && n < 8) begin
         @(negedge i_clock);
         n++;
      end
      chk("ready", 4'h1, {3'h0, o_ready});
   endtask

   task automatic gap();
      repeat ($urandom_range(1, 4)) @(posedge i_clock);
   endtask

   task automatic sys_reset(input logic by_pin);
      @(posedge i_clock);
      if (by_pin) begin
         pin_rstn <= 1'b0;
      end else begin
         usb_rst <= 1'b1;
      end
      @(posedge i_clock);
      pin_rstn <= 1'b1;
      usb_rst  <= 1'b0;
   endtask

   always @(negedge i_clock) begin
      if (!i_rstn) begin
         prev = o_state;
      end else if (o_state !== prev) begin
         prev = o_state;
         if (notes.size() == 0) begin
            chk("unexpected state", {1'b0, exp_st}, {1'b0, o_state});
         end else begin
            exp_st = notes.pop_front();
            chk("state", {1'b0, exp_st}, {1'b0, o_state});
            chk("module enables", (exp_st == UPSM_NORMAL_CFG || exp_st == UPSM_SUSP_CLOCKED) ? UPSM_MOD_ALL :
               (exp_st == UPSM_NORMAL_UNCFG) ? UPSM_MOD_UNCFG : UPSM_MOD_NONE, o_mod_en);
            chk("pll", {3'h0, exp_st == UPSM_NORMAL_CFG || exp_st == UPSM_NORMAL_UNCFG ||
               exp_st == UPSM_SUSP_CLOCKED}, {3'h0, o_pll_en});
            chk("ref clock", {3'h0, exp_st != UPSM_UNPOWERED}, {3'h0, o_ref_clk_en});
            if (exp_st != UPSM_NORMAL_UNCFG && exp_st != UPSM_NORMAL_CFG) begin
               chk("ready off", 4'h0, {3'h0, o_ready});
            end
         end
      end
   end

   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         final_report();
      end
   end

   initial begin
      sense     = 1'b0;
      usb_rst   = 1'b0;
      pin_rstn  = 1'b1;
      i_rstn    = 1'b0;
      error_cnt = 0;
      checked   = 0;
      cycles    = 0;
      exp_st    = UPSM_UNPOWERED;
      void'($urandom(32'h4cb0cc35));
      repeat (3) @(posedge i_clock);
      i_rstn <= 1'b1;
      repeat (6) @(posedge i_clock);
      @(negedge i_clock);
      chk("unpowered", {1'b0, UPSM_UNPOWERED}, {1'b0, o_state});
      chk("sel default", {2'h0, UPSM_SEL_DEEP}, {2'h0, o_suspend_sel});
      chk("reset flags", 4'h0, {o_ready, o_pll_en, o_ref_clk_en, o_configured});
      chk("reset module enables", UPSM_MOD_NONE, o_mod_en);
      step(UPSM_NORMAL_UNCFG);
      @(posedge i_clock);
      sense <= 1'b1;
      settle();
      wait_ready();
      step(UPSM_NORMAL_CFG);
      host.pulse(0, 2'h0);
      settle();
      for (int i = 0; i < 4; i++) begin
         host.pulse(2, codes[i]);
         gap();
         @(negedge i_clock);
         chk("sel write", {2'h0, codes[i]}, {2'h0, o_suspend_sel});
         step(sts[i]);
         host.suspend_bus();
         settle();
         step(UPSM_NORMAL_CFG);
         host.resume_bus(i[0]);
         settle();
         wait_ready();
         chk("context", 4'h1, {3'h0, o_configured});
         chk("context keep", 4'h1, {3'h0, o_context_keep});
         if (codes[i] == UPSM_SEL_DEEP) begin
            host.phy_reinit();
         end
      end
      host.pulse(2, UPSM_SEL_ZERO);
      step(UPSM_NORMAL_UNCFG);
      host.pulse(1, 2'h0);
      settle();
      chk("sel after deconfigure", {2'h0, UPSM_SEL_RESET}, {2'h0, o_suspend_sel});
      // any select code: unconfigured suspend must still pick the deep variant
      host.pulse(2, 2'($urandom));
      step(UPSM_SUSP_DEEP);
      host.suspend_bus();
      settle();
      step(UPSM_NORMAL_UNCFG);
      host.resume_bus(1'b0);
      settle();
      chk("context cleared", 4'h0, {3'h0, o_configured});
      chk("context keep cleared", 4'h0, {3'h0, o_context_keep});
      for (int k = 0; k < 2; k++) begin
         step(UPSM_NORMAL_CFG);
         host.pulse(0, 2'h0);
         host.pulse(2, UPSM_SEL_ONE);
         step(UPSM_SUSP_ONE);
         host.suspend_bus();
         settle();
         step(UPSM_NORMAL_UNCFG);
         sys_reset(k[0]);
         settle();
         chk("sel after reset", {2'h0, UPSM_SEL_RESET}, {2'h0, o_suspend_sel});
         host.resume_bus(1'b0);
         gap();
      end
      step(UPSM_NORMAL_CFG);
      host.pulse(0, 2'h0);
      step(UPSM_UNPOWERED);
      @(posedge i_clock);
      sense <= 1'b0;
      settle();
      chk("ready when unpowered", 4'h0, {3'h0, o_ready});
      host.suspend_bus();
      sys_reset(1'b0);
      repeat (4) @(posedge i_clock);
      @(negedge i_clock);
      chk("stays unpowered", {1'b0, UPSM_UNPOWERED}, {1'b0, o_state});
      final_report();
   end
endmodule
